// ---- src/asc_pkg.sv ----
// Constants, types and register map of the auxiliary system control bank
package asc_pkg;
	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam int ASC_ADDR_W = 12;
	localparam int ASC_IDX_W = 10;
	localparam logic [9:0] ASC_IDX_MISC = 10'h0F7;
	localparam logic [9:0] ASC_IDX_ACTION = 10'h0F8;
	localparam logic [9:0] ASC_IDX_IRQ_STATUS = 10'h0F9;
	localparam logic [9:0] ASC_IDX_IRQ_MASK = 10'h0FA;
	localparam logic [9:0] ASC_IDX_LIVE = 10'h0FB;
	// ==========================================================
	// Reset values
	localparam logic [7:0] ASC_MISC_RST = 8'h06;
	localparam logic [7:0] ASC_ACTION_RST = 8'h00;
	localparam logic [2:0] ASC_EV_RST = 3'h0;
	// ==========================================================
	// Field positions, misc register
	localparam int ASC_B_POLICY_HI = 7;
	localparam int ASC_B_POLICY_LO = 6;
	localparam int ASC_B_LOW_POWER_SAVE = 5;
	localparam int ASC_B_REFOUT = 4;
	localparam int ASC_B_WIDEDIV = 3;
	localparam int ASC_B_EE_HI = 2;
	localparam int ASC_B_EE_LO = 1;
	localparam int ASC_B_ARITH = 0;
	// Field positions, action register
	localparam int ASC_B_KICK = 7;
	localparam int ASC_B_T3CLR = 6;
	localparam int ASC_B_ADCGO = 4;
	localparam int ASC_B_PWM0 = 3;
	localparam int ASC_B_PWM1 = 2;
	// Event bits of status and mask
	localparam int ASC_EV_W = 3;
	localparam int ASC_EV_WDT = 0;
	localparam int ASC_EV_EE = 1;
	localparam int ASC_EV_ADC = 2;
	// ==========================================================
	// Misc values
	localparam logic [3:0] ASC_REF_CHAN = 4'hC;
	localparam logic [1:0] ASC_RESP_OKAY = 2'h0;
	localparam logic [1:0] ASC_RESP_SLVERR = 2'h2;
	// ==========================================================
	// Timing: EEPROM write guard times in ms, rounded up to cycles
	localparam int ASC_CLK_MHZ = 200;
	localparam real ASC_EE_T1_MS = 0.8;
	localparam real ASC_EE_T2_MS = 3.1;
	localparam real ASC_EE_T3_MS = 6.2;
	localparam int ASC_EE_C1 = int'($ceil(ASC_EE_T1_MS * 1000.0 * ASC_CLK_MHZ));
	localparam int ASC_EE_C2 = int'($ceil(ASC_EE_T2_MS * 1000.0 * ASC_CLK_MHZ));
	localparam int ASC_EE_C3 = int'($ceil(ASC_EE_T3_MS * 1000.0 * ASC_CLK_MHZ));
	localparam int ASC_EE_CNT_W = 21;
	// ==========================================================
	// Power modes reported by the clock controller
	typedef enum logic [1:0] {
		ASC_PM_FAST,
		ASC_PM_SLOW,
		ASC_PM_IDLE,
		ASC_PM_STOP
	} asc_pmode_t;
endpackage

// ---- src/asc_axil.sv ----
// AXI4-Lite slave front end for the auxiliary system control bank
`timescale 1ns/1ps
`default_nettype none
module asc_axil import asc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ASC_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ASC_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output logic [ASC_IDX_W-1:0] wr_idx,
	output logic [7:0] wr_data,
	output logic wr_lane0,
	input wire logic wr_hit,
	output logic rd_en,
	output logic [ASC_IDX_W-1:0] rd_idx,
	input wire logic [7:0] rd_data,
	input wire logic rd_hit
);
	logic aw_held;
	logic w_held;
	logic [ASC_IDX_W-1:0] aw_idx;
	logic [7:0] w_byte;
	logic w_lane;

	// ==========================================================
	// Write channel: address and data taken in either order
	assign wr_en = aw_held && w_held;
	assign wr_idx = aw_idx;
	assign wr_data = w_byte;
	assign wr_lane0 = w_lane;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			awready <= 1'b1;
			aw_idx <= '0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			awready <= 1'b0;
			aw_idx <= awaddr[ASC_ADDR_W-1:2];
		end else if (wr_en) begin
			aw_held <= 1'b0;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			wready <= 1'b1;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			wready <= 1'b0;
			w_byte <= wdata[7:0];
			w_lane <= wstrb[0];
		end else if (wr_en) begin
			w_held <= 1'b0;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	// Response one cycle after both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= ASC_RESP_OKAY;
		end else if (wr_en) begin
			bvalid <= 1'b1;
			bresp <= wr_hit ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Read channel: data sampled at the address handshake
	assign rd_en = arvalid && arready;
	assign rd_idx = araddr[ASC_ADDR_W-1:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= ASC_RESP_OKAY;
		end else if (rd_en) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h000000, rd_data};
			rresp <= rd_hit ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- src/asc_ee_guard.sv ----
// EEPROM write guard timer raising a timeout after a selected wait
`timescale 1ns/1ps
`default_nettype none
module asc_ee_guard import asc_pkg::*; #(
	parameter int CNT_1 = ASC_EE_C1,
	parameter int CNT_2 = ASC_EE_C2,
	parameter int CNT_3 = ASC_EE_C3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] sel,
	input wire logic busy,
	output logic timeout
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_COUNT,
		ST_DONE
	} asc_ee_st_t;

	asc_ee_st_t state;
	logic [ASC_EE_CNT_W-1:0] count;

	// Counts must be nonzero and fit the counter, refused at elaboration
	if (CNT_1 < 1 || CNT_2 < 1 || CNT_3 < 1 ||
		CNT_1 >= (1 << ASC_EE_CNT_W) || CNT_2 >= (1 << ASC_EE_CNT_W) ||
		CNT_3 >= (1 << ASC_EE_CNT_W)) begin : g_bad_cnt
		$error("asc_ee_guard: counts out of range");
	end

	// Limit of the selected wait; zero means the guard is off
	function automatic logic [ASC_EE_CNT_W-1:0] limit_of(input logic [1:0] s);
		case (s)
			2'b01: limit_of = ASC_EE_CNT_W'(CNT_1);
			2'b10: limit_of = ASC_EE_CNT_W'(CNT_2);
			2'b11: limit_of = ASC_EE_CNT_W'(CNT_3);
			default: limit_of = '0;
		endcase
	endfunction

	// One timeout per write; the write ending early abandons the wait
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			count <= '0;
			timeout <= 1'b0;
		end else begin
			timeout <= 1'b0;
			case (state)
				ST_IDLE: begin
					count <= '0;
					if (busy && sel != 2'b00)
						state <= ST_COUNT;
				end
				ST_COUNT: begin
					count <= count + 1'b1;
					if (!busy || sel == 2'b00) begin
						state <= ST_IDLE;
					end else if (count + 1'b1 >= limit_of(sel)) begin
						timeout <= 1'b1;
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (!busy)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_EE_OFF: assert property (sel == 2'b00 |=> !timeout)
		else $error("guard fired while disabled");
endmodule
`default_nettype wire

// ---- src/aux_system_control.sv ----
// Auxiliary system control bank: misc control, action bits, interrupts
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Policy upper bit 0 disables watchdog reset; 10 allows it in Fast/Slow.
// - Policy 11 allows watchdog reset in every power mode.
// - Power-save bit cuts consumption while in Idle or Stop.
// - Reference-out bit drives bandgap onto pin when ADC channel is 1100b.
// - Wide-divide bit picks 16/16 (0) or 32/16 (1) division.
// - Timeout field resets to 11; 00 off, else flag after 0.8/3.1/6.2 ms.
// - Writing 1 to watchdog kick restarts it; bit self-clears next cycle.
// - Writing 1 to Timer3 clear resets Timer3; bit self-clears next cycle.
// - Conversion go starts ADC; cleared at conversion end or by writing 0.
// - PWM0 hold bit set keeps PWM channel 0 cleared and stopped.
// - PWM1 hold bit set keeps PWM channel 1 cleared and stopped.
// - Action bits sit in their own register: 7,6,4,3,2.
module aux_system_control import asc_pkg::*; #(
	parameter int EE_CNT_1 = ASC_EE_C1,
	parameter int EE_CNT_2 = ASC_EE_C2,
	parameter int EE_CNT_3 = ASC_EE_C3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ASC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ASC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] power_mode,
	input wire logic wdt_overflow,
	input wire logic [3:0] adc_channel_sel,
	input wire logic adc_conv_done,
	input wire logic eeprom_write_busy,
	output logic wdt_reset,
	output logic low_power_save_active,
	output logic shared_ref_pin_sel,
	output logic wide_divide_mode,
	output logic arith_width_16,
	output logic watchdog_kick,
	output logic timer_three_clear,
	output logic adc_conversion_go,
	output logic pwm_ch0_hold,
	output logic pwm_ch1_hold,
	output logic eeprom_timeout,
	output logic irq
);
	logic [7:0] misc_system_control;
	logic [ASC_EV_W-1:0] irq_status;
	logic [ASC_EV_W-1:0] irq_mask;
	logic wr_en;
	logic [ASC_IDX_W-1:0] wr_idx;
	logic [7:0] wr_data;
	logic wr_lane0;
	logic wr_hit;
	logic rd_en;
	logic [ASC_IDX_W-1:0] rd_idx;
	logic [7:0] rd_data;
	logic rd_hit;
	logic ee_flag;
	logic wr_misc;
	logic wr_action;
	logic wr_status;
	logic wr_mask;
	logic wdt_allowed;
	logic [ASC_EV_W-1:0] events;
	asc_pmode_t pmode;

	// ==========================================================
	// Bus front end
	asc_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.wr_lane0(wr_lane0),
		.wr_hit(wr_hit),
		.rd_en(rd_en),
		.rd_idx(rd_idx),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// ==========================================================
	// Address decode, shared by the read and write paths
	function automatic logic is_mapped(input logic [ASC_IDX_W-1:0] idx);
		is_mapped = idx == ASC_IDX_MISC || idx == ASC_IDX_ACTION ||
			idx == ASC_IDX_IRQ_STATUS || idx == ASC_IDX_IRQ_MASK ||
			idx == ASC_IDX_LIVE;
	endfunction

	// Writes without byte lane 0 are accepted but change nothing
	assign wr_hit = is_mapped(wr_idx);
	assign wr_misc = wr_en && wr_lane0 && wr_idx == ASC_IDX_MISC;
	assign wr_action = wr_en && wr_lane0 && wr_idx == ASC_IDX_ACTION;
	assign wr_status = wr_en && wr_lane0 && wr_idx == ASC_IDX_IRQ_STATUS;
	assign wr_mask = wr_en && wr_lane0 && wr_idx == ASC_IDX_IRQ_MASK;
	assign rd_hit = is_mapped(rd_idx);

	// Read mux; unused bits and unmapped words read zero
	always_comb begin
		rd_data = 8'h00;
		case (rd_idx)
			ASC_IDX_MISC: rd_data = misc_system_control;
			ASC_IDX_ACTION: begin
				rd_data[ASC_B_KICK] = watchdog_kick;
				rd_data[ASC_B_T3CLR] = timer_three_clear;
				rd_data[ASC_B_ADCGO] = adc_conversion_go;
				rd_data[ASC_B_PWM0] = pwm_ch0_hold;
				rd_data[ASC_B_PWM1] = pwm_ch1_hold;
			end
			ASC_IDX_IRQ_STATUS: rd_data = {5'h00, irq_status};
			ASC_IDX_IRQ_MASK: rd_data = {5'h00, irq_mask};
			ASC_IDX_LIVE: rd_data = {5'h00, eeprom_write_busy, power_mode};
			default: rd_data = 8'h00;
		endcase
	end

	// ==========================================================
	// Misc control register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			misc_system_control <= ASC_MISC_RST;
		else if (wr_misc)
			misc_system_control <= wr_data;
	end

	// Plain mode outputs, registered so the pins never glitch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wide_divide_mode <= 1'b0;
			arith_width_16 <= 1'b0;
		end else begin
			wide_divide_mode <= misc_system_control[ASC_B_WIDEDIV];
			arith_width_16 <= misc_system_control[ASC_B_ARITH];
		end
	end

	// ==========================================================
	// Watchdog reset gating by policy and power mode
	assign pmode = asc_pmode_t'(power_mode);
	assign wdt_allowed = misc_system_control[ASC_B_POLICY_HI] &&
		(misc_system_control[ASC_B_POLICY_LO] ||
		pmode == ASC_PM_FAST || pmode == ASC_PM_SLOW);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			wdt_reset <= 1'b0;
		else
			wdt_reset <= wdt_overflow && wdt_allowed;
	end

	// Power saving only applies once the core sleeps
	always_ff @(posedge aclk) begin
		if (!aresetn)
			low_power_save_active <= 1'b0;
		else
			low_power_save_active <= misc_system_control[ASC_B_LOW_POWER_SAVE] &&
				(pmode == ASC_PM_IDLE || pmode == ASC_PM_STOP);
	end

	// Reference needs both the enable and the matching channel
	always_ff @(posedge aclk) begin
		if (!aresetn)
			shared_ref_pin_sel <= 1'b0;
		else
			shared_ref_pin_sel <= misc_system_control[ASC_B_REFOUT] &&
				adc_channel_sel == ASC_REF_CHAN;
	end

	// ==========================================================
	// Action register: one-shot kicks last exactly one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_kick <= ASC_ACTION_RST[ASC_B_KICK];
			timer_three_clear <= ASC_ACTION_RST[ASC_B_T3CLR];
		end else begin
			watchdog_kick <= wr_action && wr_data[ASC_B_KICK];
			timer_three_clear <= wr_action && wr_data[ASC_B_T3CLR];
		end
	end

	// Conversion start; a software set wins over a same-cycle done
	always_ff @(posedge aclk) begin
		if (!aresetn)
			adc_conversion_go <= ASC_ACTION_RST[ASC_B_ADCGO];
		else if (wr_action)
			adc_conversion_go <= wr_data[ASC_B_ADCGO];
		else if (adc_conv_done)
			adc_conversion_go <= 1'b0;
	end

	// PWM holds are levels kept until software drops them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwm_ch0_hold <= ASC_ACTION_RST[ASC_B_PWM0];
			pwm_ch1_hold <= ASC_ACTION_RST[ASC_B_PWM1];
		end else if (wr_action) begin
			pwm_ch0_hold <= wr_data[ASC_B_PWM0];
			pwm_ch1_hold <= wr_data[ASC_B_PWM1];
		end
	end

	// ==========================================================
	// EEPROM write guard
	asc_ee_guard #(
		.CNT_1(EE_CNT_1),
		.CNT_2(EE_CNT_2),
		.CNT_3(EE_CNT_3)
	) u_ee_guard (
		.aclk(aclk),
		.aresetn(aresetn),
		.sel(misc_system_control[ASC_B_EE_HI:ASC_B_EE_LO]),
		.busy(eeprom_write_busy),
		.timeout(ee_flag)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			eeprom_timeout <= 1'b0;
		else
			eeprom_timeout <= ee_flag;
	end

	// ==========================================================
	// Interrupts: sticky status, write one to clear, set wins
	assign events = {adc_conv_done && adc_conversion_go, ee_flag,
		wdt_overflow && wdt_allowed};

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_status <= ASC_EV_RST;
		else if (wr_status)
			irq_status <= (irq_status & ~wr_data[ASC_EV_W-1:0]) | events;
		else
			irq_status <= irq_status | events;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_mask <= ASC_EV_RST;
		else if (wr_mask)
			irq_mask <= wr_data[ASC_EV_W-1:0];
	end

	// One cycle behind status, kept registered for a clean pin
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// ==========================================================
	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence kick_written;
		wr_action && wr_data[ASC_B_KICK];
	endsequence

	sequence one_cycle_kick;
		watchdog_kick ##1 !watchdog_kick;
	endsequence

	AST_WDT_OFF: assert property (
		!misc_system_control[ASC_B_POLICY_HI] |=> !wdt_reset)
		else $error("watchdog reset while policy disabled");
	AST_WDT_SLEEP: assert property (misc_system_control[7:6] == 2'b10 &&
		(pmode == ASC_PM_IDLE || pmode == ASC_PM_STOP) |=> !wdt_reset)
		else $error("watchdog reset in sleep under policy 10");
	AST_WDT_ALWAYS: assert property (misc_system_control[7:6] == 2'b11 &&
		wdt_overflow |=> wdt_reset)
		else $error("watchdog reset missed under policy 11");
	AST_LOW_POWER_SAVE: assert property (misc_system_control[ASC_B_LOW_POWER_SAVE] &&
		pmode == ASC_PM_STOP |=> low_power_save_active)
		else $error("power save not applied in stop");
	AST_REF_PIN: assert property (shared_ref_pin_sel |->
		$past(adc_channel_sel) == ASC_REF_CHAN)
		else $error("reference driven on wrong channel");
	AST_WIDE_DIV: assert property (wr_misc ##1 1 |=>
		wide_divide_mode == $past(misc_system_control[ASC_B_WIDEDIV]))
		else $error("divide mode does not follow register");
	AST_KICK: assert property (kick_written |=> one_cycle_kick)
		else $error("watchdog kick not a single cycle");
	AST_T3_CLR: assert property (timer_three_clear |=> !timer_three_clear)
		else $error("timer three clear did not self clear");
	AST_ADC_DONE: assert property (adc_conversion_go &&
		adc_conv_done && !wr_action |=> !adc_conversion_go)
		else $error("conversion go not cleared at done");
	AST_PWM_HOLD: assert property (wr_action && wr_data[ASC_B_PWM0] &&
		!wr_data[ASC_B_PWM1] |=> pwm_ch0_hold && !pwm_ch1_hold)
		else $error("pwm hold bits do not follow write");

	// Outputs driven by writes, power mode and the guard, then the sticky status and the irq pin
	AST_ARITH: assert property (wr_misc ##1 1 |=>
		arith_width_16 == $past(misc_system_control[ASC_B_ARITH]))
		else $error("arith width does not follow register");
	AST_LOW_POWER_SAVE_AWAKE: assert property (
		pmode == ASC_PM_FAST || pmode == ASC_PM_SLOW |=> !low_power_save_active)
		else $error("power save applied while awake");
	AST_EE_PULSE: assert property (eeprom_timeout |=> !eeprom_timeout)
		else $error("eeprom timeout longer than one cycle");
	AST_T3_WRITE: assert property (
		wr_action && wr_data[ASC_B_T3CLR] |=> timer_three_clear)
		else $error("timer three clear not raised by write");
	AST_ADC_SET: assert property (
		wr_action && wr_data[ASC_B_ADCGO] |=> adc_conversion_go)
		else $error("conversion go not set by write");
	AST_PWM1_HOLD: assert property (wr_action && wr_data[ASC_B_PWM1] &&
		!wr_data[ASC_B_PWM0] |=> pwm_ch1_hold && !pwm_ch0_hold)
		else $error("pwm one hold does not follow write");
	AST_EV_STICKY: assert property (
		1 |=> (irq_status & $past(events)) == $past(events))
		else $error("event lost from status");
	AST_IRQ: assert property (|(irq_status & irq_mask) |=> irq)
		else $error("irq missing for unmasked status");
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench for the auxiliary system control bank
`timescale 1ns/1ps
`default_nettype none
module testbench import asc_pkg::*;;
	// ==========================================================
	// Signals, clock and counters
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [ASC_ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb, chan;
	logic [1:0] bresp, rresp, rr, pm, pol, power_mode;
	logic wdt_overflow, conv_done, ee_busy, wdt_reset, lps, ref_sel;
	logic wdm, aw16, kick, t3, go, h0, h1, ee_to, irq;
	logic [7:0] m;
	int n_errors, tests_run, kick_n, t3_n, rst_n, to_n, c0, c1, i, k;

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// Pulse counters; a one-cycle pulse adds exactly one
	always @(posedge aclk) begin
		kick_n <= kick_n + 32'(kick);
		t3_n <= t3_n + 32'(t3);
		rst_n <= rst_n + 32'(wdt_reset);
		to_n <= to_n + 32'(ee_to);
	end

	// Short guard counts keep the timeout test quick
	aux_system_control #(.EE_CNT_1(20), .EE_CNT_2(40), .EE_CNT_3(60))
	u_aux_system_control (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .power_mode(power_mode),
		.wdt_overflow(wdt_overflow), .adc_channel_sel(chan),
		.adc_conv_done(conv_done), .eeprom_write_busy(ee_busy),
		.wdt_reset(wdt_reset), .low_power_save_active(lps),
		.shared_ref_pin_sel(ref_sel), .wide_divide_mode(wdm),
		.arith_width_16(aw16), .watchdog_kick(kick),
		.timer_three_clear(t3), .adc_conversion_go(go),
		.pwm_ch0_hold(h0), .pwm_ch1_hold(h1), .eeprom_timeout(ee_to),
		.irq(irq));

	// ==========================================================
	// Reporting
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			n_errors++;
		end
	endtask

	task automatic print_verdict();
		$display("TB: %0d compares, %0d mismatches", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Bus master; an edge passes after release so strobes never clash
	task automatic wr(input logic [9:0] idx, input logic [7:0] d,
		input logic [1:0] er, input logic [3:0] st);
		int j;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (j = 0; j < 50; j++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		check(32'(bresp), 32'(er));
		bready <= 1'b0;
		@(posedge aclk);
		if (j == 50) begin
			n_errors++;
			print_verdict();
		end
	endtask

	task automatic rd(input logic [9:0] idx, output logic [31:0] d,
		output logic [1:0] r);
		int j;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (j = 0; j < 50; j++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
		if (j == 50) begin
			n_errors++;
			print_verdict();
		end
	endtask

	// Watchdog reset allowed: upper bit set, and 11 or an active mode
	function automatic int wdt_ok(input logic [1:0] p, input logic [1:0] md);
		return int'(p[1] && (p[0] || !md[1]));
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb, chan} = '0;
		{power_mode, wdt_overflow, conv_done, ee_busy} = 5'h00;
		void'($urandom(32'h5565015E));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ASC_IDX_MISC, rv, rr);
		check(rv, 32'h06);
		rd(ASC_IDX_ACTION, rv, rr);
		check(rv, 32'h00);
		$display("TB: reset values done");
		// Random misc settings, two corners first
		for (i = 0; i < 12; i++) begin
			m = (i == 0) ? 8'hF9 : (i == 1) ? 8'h00 : 8'($urandom);
			pm = (i == 0) ? 2'h3 : 2'($urandom);
			chan <= i[0] ? 4'hC : 4'($urandom);
			power_mode <= pm;
			wr(ASC_IDX_MISC, m, ASC_RESP_OKAY, 4'h1);
			repeat (3) @(posedge aclk);
			rd(ASC_IDX_MISC, rv, rr);
			check(rv, {24'h0, m});
			check(32'(lps), 32'(m[5] & pm[1]));
			check(32'(ref_sel), 32'(m[4] & (chan == 4'hC)));
			check(32'(wdm), 32'(m[3]));
			check(32'(aw16), 32'(m[0]));
		end
		$display("TB: misc fields done");
		// Every policy against every power mode
		for (i = 0; i < 16; i++) begin
			pol = 2'(i >> 2);
			pm = 2'(i);
			power_mode <= pm;
			wr(ASC_IDX_MISC, {pol, 6'h00}, ASC_RESP_OKAY, 4'h1);
			c0 = rst_n;
			wdt_overflow <= 1'b1;
			@(posedge aclk);
			wdt_overflow <= 1'b0;
			repeat (4) @(posedge aclk);
			check(32'(rst_n - c0), 32'(wdt_ok(pol, pm)));
		end
		$display("TB: watchdog policy done");
		// One-shot bits alone and together
		for (i = 0; i < 3; i++) begin
			m = (i == 0) ? 8'h80 : (i == 1) ? 8'h40 : 8'hC0;
			c0 = kick_n;
			c1 = t3_n;
			wr(ASC_IDX_ACTION, m, ASC_RESP_OKAY, 4'h1);
			repeat (3) @(posedge aclk);
			check(32'(kick_n - c0), 32'(m[7]));
			check(32'(t3_n - c1), 32'(m[6]));
			rd(ASC_IDX_ACTION, rv, rr);
			check(rv, 32'h00);
		end
		// Conversion go and holds; done clears go only
		wr(ASC_IDX_ACTION, 8'h1C, ASC_RESP_OKAY, 4'h1);
		rd(ASC_IDX_ACTION, rv, rr);
		check(rv, 32'h1C);
		check(32'({go, h0, h1}), 32'h7);
		conv_done <= 1'b1;
		@(posedge aclk);
		conv_done <= 1'b0;
		repeat (3) @(posedge aclk);
		check(32'({go, h0, h1}), 32'h3);
		// Each hold alone, so one channel runs while the other stops
		wr(ASC_IDX_ACTION, 8'h08, ASC_RESP_OKAY, 4'h1);
		repeat (2) @(posedge aclk);
		check(32'({go, h0, h1}), 32'h2);
		wr(ASC_IDX_ACTION, 8'h04, ASC_RESP_OKAY, 4'h1);
		repeat (2) @(posedge aclk);
		check(32'({go, h0, h1}), 32'h1);
		wr(ASC_IDX_ACTION, 8'h10, ASC_RESP_OKAY, 4'h1);
		repeat (2) @(posedge aclk);
		check(32'({go, h0, h1}), 32'h4);
		wr(ASC_IDX_ACTION, 8'h00, ASC_RESP_OKAY, 4'h1);
		repeat (2) @(posedge aclk);
		check(32'(go), 32'h0);
		$display("TB: action bits done");
		// EEPROM guard for every select value, 00 never fires
		for (i = 0; i < 4; i++) begin
			wr(ASC_IDX_MISC, 8'(i << 1), ASC_RESP_OKAY, 4'h1);
			c0 = to_n;
			ee_busy <= 1'b1;
			for (k = 0; k < 100; k++) begin
				@(posedge aclk);
				if (ee_to) break;
			end
			ee_busy <= 1'b0;
			repeat (3) @(posedge aclk);
			if (i == 0) check(32'(to_n - c0), 32'h0);
			else check(32'(k >= i * 20 && k <= i * 20 + 4), 32'h1);
		end
		$display("TB: eeprom guard done");
		// Status, mask and irq
		rd(ASC_IDX_IRQ_STATUS, rv, rr);
		check(rv, 32'h07);
		check(32'(irq), 32'h0);
		wr(ASC_IDX_IRQ_MASK, 8'h02, ASC_RESP_OKAY, 4'h1);
		repeat (2) @(posedge aclk);
		check(32'(irq), 32'h1);
		wr(ASC_IDX_IRQ_STATUS, 8'h02, ASC_RESP_OKAY, 4'h1);
		repeat (2) @(posedge aclk);
		check(32'(irq), 32'h0);
		rd(ASC_IDX_IRQ_STATUS, rv, rr);
		check(rv, 32'h05);
		// Unmapped place and a write with lane 0 off
		wr(10'h0FC, 8'hFF, ASC_RESP_SLVERR, 4'h1);
		rd(10'h0FC, rv, rr);
		check({rv[29:0], rr}, 32'h2);
		wr(ASC_IDX_MISC, 8'hFF, ASC_RESP_OKAY, 4'h0);
		rd(ASC_IDX_MISC, rv, rr);
		check(rv, 32'h06);
		rd(ASC_IDX_LIVE, rv, rr);
		check(rv, 32'h03);
		$display("TB: interrupts and bus done");
		print_verdict();
	end
endmodule
`default_nettype wire
